// ==== verilog/spi_port_defines.svh ====
// Constants of the transceiver host serial port.
// Notes on behaviour
// - Device is slave only, host drives clock.
// - Chip enable frames three or more bursts.
// - Sample on rising edge, change on falling.
// - Eight-bit bursts, most significant bit first.
// - First burst is header: address, read flag.
// - Payload flows one way only per transaction.
// - Payload is even, at least two bytes.
// - Serial shifting separate; core clock moves data. Here shifting also runs on the core clock.
// - Alternate select: line two shows CRC valid.
// - Alternate select: line one shows out-of-idle.
// - Reset low holds Off, clears serial state.
// - Reset release enters Idle with defaults.
// - Outputs tri-stated while reset is held.
// - Port serves transactions only in Idle.
`ifndef SPI_PORT_DEFINES_SVH
`define SPI_PORT_DEFINES_SVH

`define BURST_BITS 8
`define WORD_BITS 16
`define ADDR_BITS 6
`define HDR_READ_BIT 7
`define HDR_ADDR_MSB 5
`define MISO_FILL 1'b0
`define FIFO_DEPTH 4
`define SYNC_CE_RESET 1'b1
`define SYNC_LOW_RESET 1'b0

`endif

// ==== verilog/spi_port_pkg.sv ====
// Types shared by the host serial port design.
package spi_port_pkg;
	typedef enum logic [2:0] {
		ST_WAIT,
		ST_HEADER,
		ST_WRITE,
		ST_READ,
		ST_SKIP
	} port_state_t;
endpackage

// ==== verilog/spi_pin_sync.sv ====
// Two-stage pin synchroniser with edge detection.
`timescale 1ns/100ps
`default_nettype none
module spi_pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] level_o,
	output logic [WIDTH-1:0] rise_o,
	output logic [WIDTH-1:0] fall_o
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_stage2;
	logic [WIDTH-1:0] next_stage3;

	// Shift chain; stage1 is read only by stage2
	always_comb begin
		next_stage1 = async_i;
		next_stage2 = stage1;
		next_stage3 = stage2;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stage1 <= RESET_VAL;
			stage2 <= RESET_VAL;
			stage3 <= RESET_VAL;
		end else begin
			stage1 <= next_stage1;
			stage2 <= next_stage2;
			stage3 <= next_stage3;
		end
	end

	// Edges come from settled stages only
	assign level_o = stage2;
	assign rise_o = stage2 & ~stage3;
	assign fall_o = ~stage2 & stage3;
endmodule
`default_nettype wire

// ==== verilog/spi_word_fifo.sv ====
// Small flip-flop FIFO for received write words.
`timescale 1ns/100ps
`default_nettype none
module spi_word_fifo #(
	parameter int WIDTH = 22,
	parameter int DEPTH = 4
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] next_mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0] count;
	logic [PW-1:0] next_wr_ptr;
	logic [PW-1:0] next_rd_ptr;
	logic [PW:0] next_count;
	logic push;
	logic pop;

	// Wrap a pointer that need not be a power of two
	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == LAST) ? '0 : p + PW'(1);
	endfunction

	assign in_ready_o = (count != FULL);
	assign out_valid_o = (count != '0);
	assign out_data_o = mem[rd_ptr];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	// Pointer and storage update
	always_comb begin
		next_mem = mem;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count = count;
		if (push) begin
			next_mem[wr_ptr] = in_data_i;
			next_wr_ptr = bump(wr_ptr);
		end
		if (pop) begin
			next_rd_ptr = bump(rd_ptr);
		end
		if (push && !pop) begin
			next_count = count + (PW + 1)'(1);
		end else if (pop && !push) begin
			next_count = count - (PW + 1)'(1);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= '0;
			end
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			mem <= next_mem;
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end
endmodule
`default_nettype wire

// ==== verilog/transceiver_spi_host_port.sv ====
// Slave serial host port of the transceiver, run on the core clock.
`timescale 1ns/100ps
`default_nettype none
`include "spi_port_defines.svh"
module transceiver_spi_host_port
	import spi_port_pkg::*;
#(
	parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic CORE_READY_I,
	input wire logic SERIAL_CLOCK_IN_I,
	input wire logic CE_N_I,
	input wire logic MOSI_I,
	output logic MISO_O,
	output logic MISO_OE_O,
	output logic HEADER_VALID_O,
	output logic [`ADDR_BITS-1:0] ADDR_O,
	output logic IS_READ_O,
	output logic RD_REQ_O,
	input wire logic [`WORD_BITS-1:0] RD_DATA_I,
	output logic WR_VALID_O,
	input wire logic WR_READY_I,
	output logic [`ADDR_BITS-1:0] WR_ADDR_O,
	output logic [`WORD_BITS-1:0] WR_DATA_O,
	output logic WR_DROP_O,
	output logic DONE_O,
	output logic FRAME_ERR_O,
	output logic OFF_MODE_O,
	input wire logic INDICATOR_ALT_I,
	input wire logic CRC_VALID_I,
	input wire logic OUT_OF_IDLE_I,
	input wire logic LINE_ONE_OUT_I,
	input wire logic LINE_ONE_OE_I,
	input wire logic LINE_TWO_OUT_I,
	input wire logic LINE_TWO_OE_I,
	output logic GENERAL_LINE_ONE_O,
	output logic GENERAL_LINE_ONE_OE_O,
	output logic GENERAL_LINE_TWO_O,
	output logic GENERAL_LINE_TWO_OE_O
);
	localparam int FW = `ADDR_BITS + `WORD_BITS;
	localparam logic [3:0] HDR_LAST = 4'(`BURST_BITS - 1);
	localparam logic [3:0] WORD_LAST = 4'(`WORD_BITS - 1);

	////////////////////////////////////////////////////////////////////////////////
	// Pin sampling

	logic [2:0] pin_level;
	logic [2:0] pin_rise;
	logic [2:0] pin_fall;
	logic sclk_rise;
	logic sclk_fall;
	logic ce_fall;
	logic ce_rise;
	logic mosi;

	// Clock, chip enable and data share one delay, so data stays aligned
	spi_pin_sync #(
		.WIDTH(3),
		.RESET_VAL({`SYNC_LOW_RESET, `SYNC_CE_RESET, `SYNC_LOW_RESET})
	) u_sync (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.async_i({MOSI_I, CE_N_I, SERIAL_CLOCK_IN_I}),
		.level_o(pin_level),
		.rise_o(pin_rise),
		.fall_o(pin_fall)
	);

	assign sclk_rise = pin_rise[0];
	assign sclk_fall = pin_fall[0];
	assign ce_fall = pin_fall[1];
	assign ce_rise = pin_rise[1];
	assign mosi = pin_level[2];

	////////////////////////////////////////////////////////////////////////////////
	// Transaction state

	port_state_t state;
	port_state_t next_state;
	logic [3:0] bit_cnt;
	logic [3:0] next_bit_cnt;
	logic [`WORD_BITS-1:0] shift_in;
	logic [`WORD_BITS-1:0] next_shift_in;
	logic [`WORD_BITS-1:0] shift_out;
	logic [`WORD_BITS-1:0] next_shift_out;
	logic [`ADDR_BITS-1:0] addr;
	logic [`ADDR_BITS-1:0] next_addr;
	logic is_read;
	logic next_is_read;
	logic pay_odd;
	logic next_pay_odd;
	logic pay_two;
	logic next_pay_two;
	logic pay_one;
	logic next_pay_one;
	logic miso;
	logic next_miso;
	logic miso_oe;
	logic next_miso_oe;
	logic hdr_valid;
	logic next_hdr_valid;
	logic rd_req;
	logic next_rd_req;
	logic rd_load;
	logic done;
	logic next_done;
	logic frame_err;
	logic next_frame_err;
	logic drop;
	logic next_drop;
	logic push;
	logic next_push;
	logic [FW-1:0] push_data;
	logic [FW-1:0] next_push_data;
	logic off_mode;
	logic fifo_in_ready;
	logic [FW-1:0] fifo_out;
	logic [`WORD_BITS-1:0] word_in;
	logic [`BURST_BITS-1:0] hdr_in;

	// Assembled values as the last bit arrives
	assign word_in = {shift_in[`WORD_BITS-2:0], mosi};
	assign hdr_in = {shift_in[`BURST_BITS-2:0], mosi};
	assign rd_load = rd_req;

	// Count one payload byte; tracks parity and the two-byte minimum
	function automatic logic [1:0] byte_step(input logic odd, input logic one);
		byte_step = {~odd, one | odd};
	endfunction

	// Next transaction state
	always_comb begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_shift_in = shift_in;
		next_shift_out = shift_out;
		next_addr = addr;
		next_is_read = is_read;
		next_pay_odd = pay_odd;
		next_pay_one = pay_one;
		next_pay_two = pay_two;
		next_miso = miso;
		next_miso_oe = miso_oe;
		next_hdr_valid = 1'b0;
		next_rd_req = 1'b0;
		next_done = 1'b0;
		next_frame_err = 1'b0;
		next_drop = 1'b0;
		next_push = 1'b0;
		next_push_data = push_data;
		// Read data lands one cycle after the request, well before the falling edge
		if (rd_load) begin
			next_shift_out = RD_DATA_I;
		end
		if (ce_rise) begin
			// End of frame; a frame cut short or with odd payload is flagged
			if (state == ST_HEADER || state == ST_WRITE || state == ST_READ) begin
				next_done = 1'b1;
				next_frame_err = (state == ST_HEADER) || !pay_two || pay_odd
					|| (bit_cnt != 4'h0);
			end
			next_state = ST_WAIT;
			next_miso_oe = 1'b0;
			next_miso = `MISO_FILL;
		end else if (ce_fall) begin
			// Only an idle core may take a frame; otherwise sit it out
			if (CORE_READY_I && !off_mode) begin
				next_state = ST_HEADER;
				next_bit_cnt = 4'h0;
				next_pay_odd = 1'b0;
				next_pay_one = 1'b0;
				next_pay_two = 1'b0;
				next_miso_oe = 1'b1;
				next_miso = `MISO_FILL;
			end else begin
				next_state = ST_SKIP;
			end
		end else begin
			case (state)
				ST_HEADER: begin
					if (sclk_rise) begin
						next_shift_in = word_in;
						next_bit_cnt = bit_cnt + 4'h1;
						if (bit_cnt == HDR_LAST) begin
							next_bit_cnt = 4'h0;
							next_addr = hdr_in[`HDR_ADDR_MSB:0];
							next_is_read = hdr_in[`HDR_READ_BIT];
							next_hdr_valid = 1'b1;
							next_rd_req = hdr_in[`HDR_READ_BIT];
							next_state = hdr_in[`HDR_READ_BIT] ? ST_READ : ST_WRITE;
						end
					end
				end
				ST_WRITE: begin
					if (sclk_rise) begin
						next_shift_in = word_in;
						next_bit_cnt = (bit_cnt == WORD_LAST) ? 4'h0 : bit_cnt + 4'h1;
						if (bit_cnt == HDR_LAST || bit_cnt == WORD_LAST) begin
							{next_pay_odd, next_pay_one} = byte_step(pay_odd, pay_one);
							next_pay_two = pay_two | pay_one | pay_odd;
						end
						// Whole words only; host cannot be stalled, so a full queue drops
						if (bit_cnt == WORD_LAST) begin
							next_push = fifo_in_ready;
							next_drop = !fifo_in_ready;
							next_push_data = {addr, word_in};
						end
					end
				end
				ST_READ: begin
					// Change on the falling edge, most significant bit first
					if (sclk_fall && !rd_load) begin
						next_miso = shift_out[`WORD_BITS-1];
						next_shift_out = {shift_out[`WORD_BITS-2:0], 1'b0};
					end
					if (sclk_rise) begin
						next_bit_cnt = (bit_cnt == WORD_LAST) ? 4'h0 : bit_cnt + 4'h1;
						if (bit_cnt == HDR_LAST || bit_cnt == WORD_LAST) begin
							{next_pay_odd, next_pay_one} = byte_step(pay_odd, pay_one);
							next_pay_two = pay_two | pay_one | pay_odd;
						end
						// Fetch ahead at a word end; costs one spare read at frame end
						next_rd_req = (bit_cnt == WORD_LAST);
					end
				end
				ST_WAIT: begin
					next_miso_oe = 1'b0;
				end
				ST_SKIP: begin
					next_miso_oe = 1'b0;
				end
				default: begin
					next_state = ST_WAIT;
				end
			endcase
		end
	end

	// Reset clears every serial register and holds the port dormant
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state <= ST_WAIT;
			bit_cnt <= 4'h0;
			shift_in <= '0;
			shift_out <= '0;
			addr <= '0;
			is_read <= 1'b0;
			pay_odd <= 1'b0;
			pay_one <= 1'b0;
			pay_two <= 1'b0;
			miso <= `MISO_FILL;
			miso_oe <= 1'b0;
			hdr_valid <= 1'b0;
			rd_req <= 1'b0;
			done <= 1'b0;
			frame_err <= 1'b0;
			drop <= 1'b0;
			push <= 1'b0;
			push_data <= '0;
		end else begin
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			shift_in <= next_shift_in;
			shift_out <= next_shift_out;
			addr <= next_addr;
			is_read <= next_is_read;
			pay_odd <= next_pay_odd;
			pay_one <= next_pay_one;
			pay_two <= next_pay_two;
			miso <= next_miso;
			miso_oe <= next_miso_oe;
			hdr_valid <= next_hdr_valid;
			rd_req <= next_rd_req;
			done <= next_done;
			frame_err <= next_frame_err;
			drop <= next_drop;
			push <= next_push;
			push_data <= next_push_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Write word queue toward the core

	spi_word_fifo #(
		.WIDTH(FW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.in_valid_i(push),
		.in_ready_o(fifo_in_ready),
		.in_data_i(push_data),
		.out_valid_o(WR_VALID_O),
		.out_ready_i(WR_READY_I),
		.out_data_o(fifo_out)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Mode and indicator lines

	logic next_off_mode;
	logic line_one;
	logic line_one_oe;
	logic line_two;
	logic line_two_oe;
	logic next_line_one;
	logic next_line_one_oe;
	logic next_line_two;
	logic next_line_two_oe;

	// Off only under reset; release always lands in Idle
	always_comb begin
		next_off_mode = 1'b0;
		if (INDICATOR_ALT_I) begin
			next_line_one = OUT_OF_IDLE_I;
			next_line_one_oe = 1'b1;
			next_line_two = CRC_VALID_I;
			next_line_two_oe = 1'b1;
		end else begin
			next_line_one = LINE_ONE_OUT_I;
			next_line_one_oe = LINE_ONE_OE_I;
			next_line_two = LINE_TWO_OUT_I;
			next_line_two_oe = LINE_TWO_OE_I;
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			off_mode <= 1'b1;
			line_one <= 1'b0;
			line_one_oe <= 1'b0;
			line_two <= 1'b0;
			line_two_oe <= 1'b0;
		end else begin
			off_mode <= next_off_mode;
			line_one <= next_line_one;
			line_one_oe <= next_line_one_oe;
			line_two <= next_line_two;
			line_two_oe <= next_line_two_oe;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign MISO_O = miso;
	assign MISO_OE_O = miso_oe;
	assign HEADER_VALID_O = hdr_valid;
	assign ADDR_O = addr;
	assign IS_READ_O = is_read;
	assign RD_REQ_O = rd_req;
	assign WR_ADDR_O = fifo_out[FW-1:`WORD_BITS];
	assign WR_DATA_O = fifo_out[`WORD_BITS-1:0];
	assign WR_DROP_O = drop;
	assign DONE_O = done;
	assign FRAME_ERR_O = frame_err;
	assign OFF_MODE_O = off_mode;
	assign GENERAL_LINE_ONE_O = line_one;
	assign GENERAL_LINE_ONE_OE_O = line_one_oe;
	assign GENERAL_LINE_TWO_O = line_two;
	assign GENERAL_LINE_TWO_OE_O = line_two_oe;
endmodule
`default_nettype wire

// ==== sim/spi_port_monitor.sv ====
// Concurrent checks on the pins of the host serial port.
`timescale 1ns/100ps
`default_nettype none
`include "spi_port_defines.svh"
module spi_port_monitor #(
	parameter int FIFO_DEPTH = 4
) (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic CORE_READY_I,
	input wire logic CE_N_I,
	input wire logic WR_READY_I,
	input wire logic INDICATOR_ALT_I,
	input wire logic CRC_VALID_I,
	input wire logic OUT_OF_IDLE_I,
	input wire logic LINE_ONE_OUT_I,
	input wire logic LINE_ONE_OE_I,
	input wire logic LINE_TWO_OUT_I,
	input wire logic LINE_TWO_OE_I,
	input wire logic MISO_O,
	input wire logic MISO_OE_O,
	input wire logic HEADER_VALID_O,
	input wire logic IS_READ_O,
	input wire logic RD_REQ_O,
	input wire logic WR_VALID_O,
	input wire logic [`WORD_BITS-1:0] WR_DATA_O,
	input wire logic DONE_O,
	input wire logic FRAME_ERR_O,
	input wire logic OFF_MODE_O,
	input wire logic GENERAL_LINE_ONE_O,
	input wire logic GENERAL_LINE_ONE_OE_O,
	input wire logic GENERAL_LINE_TWO_O,
	input wire logic GENERAL_LINE_TWO_OE_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	////////////////////////////////////////////////////////////////
	// Indicator lines, one registered cycle behind their sources
	property p_line_two;
		$past(RST_N_I) && $past(INDICATOR_ALT_I) |->
			GENERAL_LINE_TWO_O == $past(CRC_VALID_I) && GENERAL_LINE_TWO_OE_O;
	endproperty
	a_line_two: assert property (p_line_two) else $error("line two not crc");
	property p_line_one;
		$past(RST_N_I) && $past(INDICATOR_ALT_I) |->
			GENERAL_LINE_ONE_O == $past(OUT_OF_IDLE_I) && GENERAL_LINE_ONE_OE_O;
	endproperty
	a_line_one: assert property (p_line_one) else $error("line one not idle flag");
	property p_line_norm;
		$past(RST_N_I) && !$past(INDICATOR_ALT_I) |-> GENERAL_LINE_ONE_O == $past(LINE_ONE_OUT_I)
			&& GENERAL_LINE_ONE_OE_O == $past(LINE_ONE_OE_I);
	endproperty
	a_line_norm: assert property (p_line_norm) else $error("line one lost normal use");
	property p_line_norm2;
		$past(RST_N_I) && !$past(INDICATOR_ALT_I) |-> GENERAL_LINE_TWO_O == $past(LINE_TWO_OUT_I)
			&& GENERAL_LINE_TWO_OE_O == $past(LINE_TWO_OE_I);
	endproperty
	a_line_norm2: assert property (p_line_norm2) else $error("line two lost normal use");
	////////////////////////////////////////////////////////////////
	// Mode and serial output
	property p_off;
		$past(RST_N_I) |-> !OFF_MODE_O;
	endproperty
	a_off: assert property (p_off) else $error("off mode after release");
	property p_idle_rel;
		CE_N_I [*6] |-> !MISO_OE_O;
	endproperty
	a_idle_rel: assert property (p_idle_rel) else $error("miso driven while idle");
	property p_not_ready;
		!CORE_READY_I [*8] |-> !MISO_OE_O;
	endproperty
	a_not_ready: assert property (p_not_ready) else $error("served out of idle");
	property p_fill;
		MISO_OE_O && !IS_READ_O |-> MISO_O == `MISO_FILL;
	endproperty
	a_fill: assert property (p_fill) else $error("miso not fill");
	////////////////////////////////////////////////////////////////
	// Frame events
	property p_hdr_rd;
		HEADER_VALID_O |-> RD_REQ_O == IS_READ_O;
	endproperty
	a_hdr_rd: assert property (p_hdr_rd) else $error("read request mismatch");
	property p_err_done;
		FRAME_ERR_O |-> DONE_O;
	endproperty
	a_err_done: assert property (p_err_done) else $error("error without done");
	property p_done_ce;
		DONE_O |-> CE_N_I && $past(CE_N_I);
	endproperty
	a_done_ce: assert property (p_done_ce) else $error("done before chip enable rose");
	property p_head_hold;
		WR_VALID_O && !WR_READY_I |=> WR_VALID_O && $stable(WR_DATA_O);
	endproperty
	a_head_hold: assert property (p_head_hold) else $error("queue head moved");
endmodule
bind transceiver_spi_host_port spi_port_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) spi_port_monitor_i (
	.CLK_I(CLK_I), .RST_N_I(RST_N_I), .CORE_READY_I(CORE_READY_I), .CE_N_I(CE_N_I),
	.WR_READY_I(WR_READY_I), .INDICATOR_ALT_I(INDICATOR_ALT_I), .CRC_VALID_I(CRC_VALID_I),
	.OUT_OF_IDLE_I(OUT_OF_IDLE_I), .LINE_ONE_OUT_I(LINE_ONE_OUT_I),
	.LINE_ONE_OE_I(LINE_ONE_OE_I), .LINE_TWO_OUT_I(LINE_TWO_OUT_I),
	.LINE_TWO_OE_I(LINE_TWO_OE_I), .MISO_O(MISO_O), .MISO_OE_O(MISO_OE_O),
	.HEADER_VALID_O(HEADER_VALID_O), .IS_READ_O(IS_READ_O), .RD_REQ_O(RD_REQ_O),
	.WR_VALID_O(WR_VALID_O), .WR_DATA_O(WR_DATA_O), .DONE_O(DONE_O),
	.FRAME_ERR_O(FRAME_ERR_O), .OFF_MODE_O(OFF_MODE_O),
	.GENERAL_LINE_ONE_O(GENERAL_LINE_ONE_O), .GENERAL_LINE_ONE_OE_O(GENERAL_LINE_ONE_OE_O),
	.GENERAL_LINE_TWO_O(GENERAL_LINE_TWO_O), .GENERAL_LINE_TWO_OE_O(GENERAL_LINE_TWO_OE_O)
);
`default_nettype wire

// ==== sim/spi_host_model.sv ====
// Behavioural host that masters the serial link.
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
	output logic sclk_o,
	output logic ce_n_o,
	output logic mosi_o,
	input wire logic miso_i,
	input wire logic miso_oe_i
);
	// Clock idles low and stands still outside frames
	initial begin
		sclk_o = 1'b0;
		ce_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// One framed transaction, nb bits MSB first; released miso reads unknown
	task automatic frame(input logic [95:0] tx, input int nb, output logic [95:0] rx);
		rx = '0;
		#31 ce_n_o = 1'b0;
		for (int i = nb - 1; i >= 0; i--) begin
			mosi_o = tx[i];
			#100 sclk_o = 1'b1;
			rx = {rx[94:0], miso_oe_i ? miso_i : 1'bx};
			#100 sclk_o = 1'b0;
		end
		// Released data line must not keep its last value
		mosi_o = ~mosi_o;
		#100 ce_n_o = 1'b1;
		#300;
	endtask
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench of the host serial port with a model host.
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ready = 1'b1;
	logic wr_ready = 1'b0;
	logic [6:0] ind = 7'h00;
	logic [15:0] rd_data = 16'h0000;
	logic [15:0] rd_q[$];
	logic [95:0] tx, rx;
	logic [7:0] hdr;
	logic [31:0] seed = 32'hddf3;
	wire sclk, ce_n, mosi, miso, miso_oe, hv, is_rd, rd_req, wr_valid, drop, done, ferr, off;
	wire [5:0] addr, wr_addr;
	wire [15:0] wr_data;
	wire l1oe, l2oe;
	int fails = 0, compares = 0, n_hv = 0, n_done = 0, n_err = 0, n_drop = 0;
	int s_hv, s_done, s_err, s_drop;
	int bad[4] = '{8, 16, 20, 32};
	always #12.5 clk = ~clk;
	////////////////////////////////////////////////////////////////
	spi_host_model spi_host_model_i (.sclk_o(sclk), .ce_n_o(ce_n), .mosi_o(mosi),
		.miso_i(miso), .miso_oe_i(miso_oe));
	transceiver_spi_host_port #(.FIFO_DEPTH(4)) transceiver_spi_host_port_i (
		.CLK_I(clk), .RST_N_I(rst_n), .CORE_READY_I(ready), .SERIAL_CLOCK_IN_I(sclk),
		.CE_N_I(ce_n), .MOSI_I(mosi), .MISO_O(miso), .MISO_OE_O(miso_oe),
		.HEADER_VALID_O(hv), .ADDR_O(addr), .IS_READ_O(is_rd), .RD_REQ_O(rd_req),
		.RD_DATA_I(rd_data), .WR_VALID_O(wr_valid), .WR_READY_I(wr_ready),
		.WR_ADDR_O(wr_addr), .WR_DATA_O(wr_data), .WR_DROP_O(drop), .DONE_O(done),
		.FRAME_ERR_O(ferr), .OFF_MODE_O(off), .INDICATOR_ALT_I(ind[0]),
		.CRC_VALID_I(ind[1]), .OUT_OF_IDLE_I(ind[2]), .LINE_ONE_OUT_I(ind[3]),
		.LINE_ONE_OE_I(ind[4]), .LINE_TWO_OUT_I(ind[5]), .LINE_TWO_OE_I(ind[6]),
		.GENERAL_LINE_ONE_O(), .GENERAL_LINE_ONE_OE_O(l1oe), .GENERAL_LINE_TWO_O(),
		.GENERAL_LINE_TWO_OE_O(l2oe));
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Word the core returns for the n-th read request of a frame
	function automatic logic [15:0] rd_word(input int n);
		return 16'h6b29 ^ 16'(n * 311);
	endfunction
	// Pulses are tallied on the edge where they stand
	always @(posedge clk) begin
		if (hv === 1'b1) n_hv++;
		if (done === 1'b1) n_done++;
		if (ferr === 1'b1) n_err++;
		if (drop === 1'b1) n_drop++;
	end
	// Indicators churn at random; each read request gets a known word next edge
	always @(negedge clk) begin
		ind <= 7'(rnd());
		if (rd_req === 1'b1) begin
			rd_data <= rd_word(rd_q.size());
			rd_q.push_back(rd_word(rd_q.size()));
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [95:0] got, input logic [95:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t %s got %0h want %0h", $time, what, got, exp);
		end
	endtask
	task automatic check_cnt(input int got, input int exp, input string what);
		check(96'(got), 96'(exp), what);
	endtask
	task automatic wrap_up();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Random draws only right after a rising edge, away from the negedge draws
	task automatic fresh(input logic [1:0] top);
		@(posedge clk);
		tx = {rnd(), rnd(), rnd()};
		hdr = {top, tx[5:0]};
	endtask
	task automatic send(input int nb);
		s_hv = n_hv;
		s_done = n_done;
		s_err = n_err;
		s_drop = n_drop;
		rd_q.delete();
		tx[nb-1 -: 8] = hdr;
		spi_host_model_i.frame(tx, nb, rx);
	endtask
	// A hang counts as a mismatch
	initial begin
		#600000;
		fails++;
		wrap_up();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk);
		check({off, miso_oe, l1oe, l2oe}, 4'b1000, "reset state");
		@(negedge clk) rst_n = 1'b1;
		repeat (6) @(posedge clk);
		check(off, 1'b0, "off after release");
		// Five words into a stalled queue of four: last one dropped
		fresh(2'b00);
		send(88);
		check({is_rd, addr}, {1'b0, hdr[5:0]}, "write header");
		check(rx[87:0], 88'h0, "fill on miso");
		check_cnt(n_drop - s_drop, 1, "drop");
		check_cnt(n_done - s_done, 1, "write done");
		check_cnt(n_err - s_err, 0, "write clean");
		check_cnt(n_hv - s_hv, 1, "header pulse");
		for (int k = 0; k < 4; k++) begin
			check({wr_valid, wr_addr, wr_data}, {1'b1, hdr[5:0], tx[79-16*k -: 16]}, "word");
			@(negedge clk) wr_ready = 1'b1;
			@(negedge clk) wr_ready = 1'b0;
		end
		check(wr_valid, 1'b0, "queue empty");
		$display("test write done");
		// Read of two words, data returned MSB first on miso
		fresh(2'b10);
		send(40);
		check({is_rd, addr}, {1'b1, hdr[5:0]}, "read header");
		check(rx[39:0], {8'h00, rd_q[0], rd_q[1]}, "read data");
		check_cnt(rd_q.size(), 3, "read requests");
		check_cnt(n_done - s_done, 1, "read done");
		check_cnt(n_err - s_err, 0, "read clean");
		$display("test read done");
		// Short, odd and partial frames are flagged
		@(negedge clk) wr_ready = 1'b1;
		foreach (bad[i]) begin
			fresh(2'(rnd()));
			send(bad[i]);
			check_cnt(n_done - s_done, 1, "bad done");
			check_cnt(n_err - s_err, 1, "bad flagged");
		end
		@(negedge clk) wr_ready = 1'b0;
		$display("test errors done");
		// Core not in idle: frame ignored
		@(negedge clk) ready = 1'b0;
		fresh(2'b00);
		send(24);
		check_cnt(n_hv - s_hv + n_done - s_done, 0, "ignored");
		check(wr_valid, 1'b0, "nothing queued");
		@(negedge clk) ready = 1'b1;
		$display("test not ready done");
		// Reset in mid-frame, after a word was queued, then a fresh frame
		fresh(2'b00);
		fork
			send(40);
			begin
				repeat (230) @(negedge clk);
				rst_n = 1'b0;
			end
		join
		check({off, miso_oe, wr_valid, l1oe, l2oe}, 5'b10000, "reset mid-frame");
		@(negedge clk) rst_n = 1'b1;
		repeat (6) @(posedge clk);
		fresh(2'b00);
		send(24);
		check({wr_valid, wr_addr, wr_data}, {1'b1, hdr[5:0], tx[15:0]}, "after reset");
		$display("test reset done");
		wrap_up();
	end
endmodule
`default_nettype wire
